// file: inc/adc_link_if.sv
// Purpose: three-wire serial link between converter and host
// Assumes: host drives select and serial clock
// Notes:   data pin resolved from the device's enable
`timescale 1ns/1ns
interface adc_link_if;
    logic cs_n;
    logic sck;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;
    // pin level seen by the host; floats high when released
    assign sdo = sdo_oe ? sdo_o : 1'b1;
    modport device (input cs_n, input sck, output sdo_o, output sdo_oe);
    modport host   (output cs_n, output sck, input sdo);
endinterface

// file: inc/adc_link_pkg.sv
// Purpose: shared constants for the sampling converter serial link
// Assumes: system clock of 100 MHz on both ends
// Notes:   link pins are sampled, never used as clocks
package adc_link_pkg;
    localparam int RESULT_BITS      = 12;
    localparam int CONV_EDGES       = 14;   // falling edges that finish a conversion
    localparam int HIZ_EDGE         = 16;   // output released after this edge
    localparam int NAP_PULSES       = 2;
    localparam int SLEEP_PULSES     = 4;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SETUP_DELAY_NS   = 5;    // frame_end_setup_delay
    localparam int SETUP_DELAY_CYC  = (SETUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_PERIOD_CYC  = 4;    // host divider half period
    localparam int ACQ_CYC          = 8;    // acquisition_window in system clocks
    localparam logic [11:0] RESULT_RESET = 12'h000;
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_NAP    = 2'b01,
        PWR_SLEEP  = 2'b10
    } power_type;
    typedef enum logic [1:0] {
        ACQ_LOW  = 2'b00,
        ACQ_HIGH = 2'b01,
        ACQ_RUN  = 2'b10
    } acq_mode_type;
endpackage

// file: src/adc_device_end.sv
// Purpose: converter end: frames, conversion, serial readout, power-down
// Assumes: cs_n and sck arrive asynchronously and are synchronised here
// Notes:   sample value enters on sample_in when the frame starts
`timescale 1ns/1ns
module adc_device_end
    import adc_link_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic                   clk_en,
    adc_link_if.device                  link,
    input  wire logic [RESULT_BITS-1:0] sample_in,
    output logic      [RESULT_BITS-1:0] result_out,
    output logic                        result_valid,
    output logic                        conv_abort,
    output power_type                   power_state,
    output logic                        sampling
);
    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for the link pins
    logic [1:0] cs_sync_q;
    logic [1:0] sck_sync_q;
    logic       cs_prev_q;
    logic       sck_prev_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_sync_q  <= 2'h3;
            sck_sync_q <= 2'h0;
            cs_prev_q  <= 1'b1;
            sck_prev_q <= 1'b0;
        end else if (clk_en) begin
            cs_sync_q  <= {cs_sync_q[0], link.cs_n};
            sck_sync_q <= {sck_sync_q[0], link.sck};
            cs_prev_q  <= cs_sync_q[1];
            sck_prev_q <= sck_sync_q[1];
        end
    end
    logic cs_fall;
    logic cs_rise;
    logic sck_fall;
    logic sck_rise;
    logic cs_low;
    assign cs_low   = !cs_sync_q[1];
    assign cs_fall  = clk_en && cs_prev_q && !cs_sync_q[1];
    assign cs_rise  = clk_en && !cs_prev_q && cs_sync_q[1];
    assign sck_fall = clk_en && sck_prev_q && !sck_sync_q[1];
    assign sck_rise = clk_en && !sck_prev_q && sck_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // acquisition clock pattern: low only while idle means one leading zero
    logic sck_seen_high_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            sck_seen_high_q <= 1'b0;
        else if (clk_en) begin
            if (cs_rise)
                sck_seen_high_q <= sck_sync_q[1];
            else if (!cs_low && sck_sync_q[1])
                sck_seen_high_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // falling edge counter within a frame
    logic [4:0] edge_cnt_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            edge_cnt_q <= 5'h00;
        else if (clk_en) begin
            if (cs_fall)
                edge_cnt_q <= 5'h00;
            else if (cs_low && sck_fall && edge_cnt_q != 5'h1F)
                edge_cnt_q <= edge_cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion: sample latched at frame start, kept only if complete
    logic [RESULT_BITS-1:0] conv_q;
    logic [RESULT_BITS-1:0] prev_q;
    logic                   done_q;
    logic [1:0]             setup_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_q  <= RESULT_RESET;
            done_q  <= 1'b0;
            setup_q <= 2'h0;
        end else if (clk_en) begin
            if (cs_fall) begin
                conv_q  <= sample_in;
                done_q  <= 1'b0;
                setup_q <= 2'h0;
            end else if (cs_low && edge_cnt_q >= 5'(CONV_EDGES)) begin
                if (setup_q < 2'(SETUP_DELAY_CYC))
                    setup_q <= setup_q + 2'h1;
                else
                    done_q <= 1'b1;
            end
        end
    end

    // finished result becomes the next frame's readout
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_q       <= RESULT_RESET;
            result_valid <= 1'b0;
            conv_abort   <= 1'b0;
            result_out   <= RESULT_RESET;
        end else if (clk_en) begin
            result_valid <= 1'b0;
            conv_abort   <= 1'b0;
            if (cs_rise && power_state == PWR_ACTIVE) begin
                if (done_q) begin
                    prev_q       <= conv_q;
                    result_out   <= conv_q;
                    result_valid <= 1'b1;
                end else
                    conv_abort <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial output: leading zeros, result, trailing zeros
    logic [RESULT_BITS+1:0] shift_q;
    logic                   sdo_q;
    logic                   oe_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_q <= '0;
            sdo_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else if (clk_en) begin
            if (!cs_low || power_state != PWR_ACTIVE) begin
                oe_q  <= 1'b0;
                sdo_q <= 1'b0;
            end else if (cs_fall) begin
                sdo_q <= 1'b0;
                oe_q  <= 1'b1;
                if (sck_seen_high_q)
                    shift_q <= {1'b0, prev_q, 1'b0};
                else
                    shift_q <= {prev_q, 2'b00};
            end else if (sck_fall) begin
                sdo_q   <= shift_q[RESULT_BITS+1];
                shift_q <= {shift_q[RESULT_BITS:0], 1'b0};
                if (edge_cnt_q + 5'h01 >= 5'(HIZ_EDGE))
                    oe_q <= 1'b0;
            end
        end
    end
    assign link.sdo_o  = sdo_q;
    assign link.sdo_oe = oe_q;
    assign sampling    = !cs_low;

    ////////////////////////////////////////////////////////////////////////
    // power-down: count select pulses with the clock static
    logic [2:0] pulse_cnt_q;
    power_type  power_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pulse_cnt_q <= 3'h0;
            power_q     <= PWR_ACTIVE;
        end else if (clk_en) begin
            if (sck_rise) begin
                pulse_cnt_q <= 3'h0;
                power_q     <= PWR_ACTIVE;
            end else if (cs_rise && edge_cnt_q == 5'h00) begin
                if (pulse_cnt_q != 3'h7)
                    pulse_cnt_q <= pulse_cnt_q + 3'h1;
                if (pulse_cnt_q + 3'h1 >= 3'(SLEEP_PULSES))
                    power_q <= PWR_SLEEP;
                else if (pulse_cnt_q + 3'h1 >= 3'(NAP_PULSES))
                    power_q <= PWR_NAP;
            end else if (cs_rise)
                pulse_cnt_q <= 3'h0;
        end
    end
    assign power_state = power_q;
endmodule

// file: src/adc_host_end.sv
// Purpose: host end: frames reads, makes the serial clock, collects bits
// Assumes: device follows the three-wire framing
// Notes:   burst clock, held high during acquisition
`timescale 1ns/1ns
module adc_host_end
    import adc_link_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic                   clk_en,
    adc_link_if.host                    link,
    input  wire logic                   start,
    output logic                        busy,
    output logic [RESULT_BITS-1:0]      data_out,
    output logic                        data_valid
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_RUN  = 2'b01,
        H_HOLD = 2'b10,
        H_ACQ  = 2'b11
    } hstate_type;

    ////////////////////////////////////////////////////////////////////////
    // data pin synchroniser
    logic [1:0] sdo_sync_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            sdo_sync_q <= 2'h0;
        else if (clk_en)
            sdo_sync_q <= {sdo_sync_q[0], link.sdo};
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer with divided serial clock
    hstate_type state_q;
    logic [3:0] div_q;
    logic [4:0] fall_q;
    logic       sck_q;
    logic       cs_n_q;
    logic [15:0] rx_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q    <= H_IDLE;
            div_q      <= 4'h0;
            fall_q     <= 5'h00;
            sck_q      <= 1'b1;
            cs_n_q     <= 1'b1;
            rx_q       <= 16'h0000;
            data_out   <= RESULT_RESET;
            data_valid <= 1'b0;
        end else if (clk_en) begin
            data_valid <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (start) begin
                        cs_n_q  <= 1'b0;
                        fall_q  <= 5'h00;
                        div_q   <= 4'h0;
                        state_q <= H_RUN;
                    end
                end
                H_RUN: begin
                    if (div_q == 4'(HALF_PERIOD_CYC - 1)) begin
                        div_q <= 4'h0;
                        sck_q <= !sck_q;
                        if (sck_q)
                            fall_q <= fall_q + 5'h01;
                        else
                            rx_q <= {rx_q[14:0], sdo_sync_q[1]};
                        if (!sck_q && fall_q == 5'(HIZ_EDGE))
                            state_q <= H_HOLD;
                    end else
                        div_q <= div_q + 4'h1;
                end
                H_HOLD: begin
                    if (div_q == 4'(SETUP_DELAY_CYC + 1)) begin
                        cs_n_q     <= 1'b1;
                        data_out   <= rx_q[13:2];   // capture lags one fall, two leading zeros
                        data_valid <= 1'b1;
                        div_q      <= 4'h0;
                        state_q    <= H_ACQ;
                    end else
                        div_q <= div_q + 4'h1;
                end
                H_ACQ: begin
                    if (div_q == 4'(ACQ_CYC - 1))
                        state_q <= H_IDLE;
                    else
                        div_q <= div_q + 4'h1;
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end
    assign link.cs_n = cs_n_q;
    assign link.sck  = sck_q;
    assign busy      = state_q != H_IDLE;
endmodule

// file: verification/adc_link_chk.sv
// Purpose: assertions on the serial link between host end and device end
// Assumes: host holds sck high in acquisition
// Notes:   edge counts are taken from the raw pins
`timescale 1ns/1ns
module adc_link_chk
    import adc_link_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    logic       sck_q;
    logic       cs_q;
    logic [4:0] falls_q;
    logic [3:0] since_q;
    logic       sck_fall;
    logic       cs_fall;

    ////////////////////////////////////////////////////////////////
    // edge finders
    assign sck_fall = sck_q && !sck;
    assign cs_fall  = cs_q && !cs_n;

    // previous pin levels
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sck_q <= 1'b1;
            cs_q  <= 1'b1;
        end else begin
            sck_q <= sck;
            cs_q  <= cs_n;
        end
    end

    // falling clock edges within a frame
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            falls_q <= 5'h00;
        else if (cs_n)
            falls_q <= 5'h00;
        else if (sck_fall && falls_q != 5'h1F)
            falls_q <= falls_q + 5'h01;
    end

    // cycles since the last edge that may move the output
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            since_q <= 4'hF;
        else if (sck_fall || cs_fall)
            since_q <= 4'h0;
        else if (since_q != 4'hF)
            since_q <= since_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence frame_open;
        $fell(cs_n);
    endsequence
    sequence zero_out;
        sdo_oe && !sdo_o;
    endsequence

    chk_select_opens: assert property (frame_open |-> ##[1:5] zero_out)
        else $error("output not driven low after select fall");
    chk_release_high: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("output driven while select high");
    chk_edge_change: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> since_q <= 4'h6)
        else $error("output moved without a clock fall");
    chk_lead_zeros: assert property (sdo_oe && falls_q < 5'h02 |-> !sdo_o)
        else $error("leading zero missing");
    chk_trail_zeros: assert property (sdo_oe && falls_q >= 5'h0E && since_q > 4'h6 |-> !sdo_o)
        else $error("trailing bit not zero");
    chk_hiz_after_16: assert property (falls_q == 5'h10 && since_q == 4'h0 |-> ##[1:6] !sdo_oe)
        else $error("output not released after last edge");
    chk_host_span: assert property ($rose(cs_n) |-> falls_q >= 5'h0E)
        else $error("select raised before fourteenth fall");
    chk_acq_clock_high: assert property (cs_n [*4] |-> sck)
        else $error("serial clock low during acquisition");
endmodule

// file: verification/tb_sar_adc_serial_readout.sv
// Purpose: both link ends back to back, plus a bench-driven device end
// Assumes: 100 MHz clock, link clock of 80 ns made by the bench
// Notes:   second link breaks the framing on purpose
`timescale 1ns/1ns
module tb_sar_adc_serial_readout
    import adc_link_pkg::*;
;
    logic        clock     = 1'b0;
    logic        rstn      = 1'b0;
    logic        start     = 1'b0;
    logic [11:0] sample_a  = 12'h000;
    logic [11:0] sample_b  = 12'h000;
    logic [11:0] data_out, res_a, res_b, prev;
    logic        data_valid, busy, valid_a, abort_a, samp_a, valid_b, abort_b, samp_b;
    power_type   pwr_a, pwr_b;
    logic [15:0] wire_bits, bits_b;
    logic [11:0] tab [4]   = '{12'hA5C, 12'hFFF, 12'h001, 12'h800};
    int          failures  = 0;
    int          compares  = 0;
    int          aborts    = 0;
    int          valids    = 0;

    adc_link_if link();
    adc_link_if link_b();

    always #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////
    adc_host_end adc_host_end_i (.clock, .rstn, .clk_en(1'b1), .link(link), .start(start), .busy(busy),
        .data_out(data_out), .data_valid(data_valid));
    adc_device_end adc_device_end_i (.clock, .rstn, .clk_en(1'b1), .link(link), .sample_in(sample_a),
        .result_out(res_a), .result_valid(valid_a), .conv_abort(abort_a), .power_state(pwr_a), .sampling(samp_a));
    adc_device_end adc_device_end_i2 (.clock, .rstn, .clk_en(1'b1), .link(link_b), .sample_in(sample_b),
        .result_out(res_b), .result_valid(valid_b), .conv_abort(abort_b), .power_state(pwr_b), .sampling(samp_b));
    adc_link_chk adc_link_chk_i (.clock, .rstn, .cs_n(link.cs_n), .sck(link.sck), .sdo_o(link.sdo_o),
        .sdo_oe(link.sdo_oe));

    // wire bits seen at each clock fall, before the device moves them
    always @(negedge link.sck) if (link.cs_n === 1'b0) wire_bits = {wire_bits[14:0], link.sdo};
    // abort and result pulses of the bench-driven end, sampled mid-cycle
    always @(negedge clock) if (abort_b === 1'b1) aborts++;
    always @(negedge clock) if (valid_b === 1'b1) valids++;

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one read through the host end, bounded waits
    task automatic host_read(input logic [11:0] s);
        int k;
        sample_a = s;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        for (k = 0; k < 400 && data_valid !== 1'b1; k++) cyc(1);
        if (k == 400) failures++;
        for (k = 0; k < 40 && busy !== 1'b0; k++) cyc(1);
        cyc(10);
    endtask

    // bench frame on the second link, clock low between frames
    task automatic frame_b(input int n, input logic [11:0] s);
        sample_b = s;
        link_b.cs_n = 1'b0;
        repeat (n) begin
            cyc(4);
            link_b.sck = 1'b1;
            cyc(4);
            bits_b = {bits_b[14:0], link_b.sdo};
            link_b.sck = 1'b0;
        end
        cyc(4);
        link_b.cs_n = 1'b1;
        cyc(12);
    endtask

    // single clock pulse with select high
    task automatic wake_b;
        link_b.sck = 1'b1;
        cyc(4);
        link_b.sck = 1'b0;
        cyc(8);
    endtask

    task automatic stop_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        link_b.cs_n = 1'b1;
        link_b.sck = 1'b0;
        bits_b = 16'h0000;
        wire_bits = 16'h0000;
        prev = RESULT_RESET;
        cyc(3);
        rstn = 1'b1;
        foreach (tab[i]) begin
            host_read(tab[i]);
            check({4'h0, data_out}, {4'h0, prev});
            check(wire_bits, {2'b00, prev, 2'b00});
            check({4'h0, res_a}, {4'h0, tab[i]});
            check({15'h0, samp_a}, 16'h0001);
            prev = tab[i];
        end
        check({14'h0, pwr_a}, {14'h0, PWR_ACTIVE});
        $display("test host to device done");
        frame_b(16, 12'h3C6);
        check(bits_b, {1'b0, RESULT_RESET, 3'b000});
        check({15'h0, samp_b}, 16'h0001);
        frame_b(16, 12'h5A9);
        check(bits_b, {1'b0, 12'h3C6, 3'b000});
        frame_b(13, 12'h111);
        check(16'(aborts), 16'h0001);
        check({4'h0, res_b}, {4'h0, 12'h5A9});
        frame_b(14, 12'h333);
        check({2'b00, bits_b[13:0]}, {3'b000, 12'h5A9, 1'b0});
        check({4'h0, res_b}, {4'h0, 12'h333});
        check(16'(aborts), 16'h0001);
        check(16'(valids), 16'h0003);
        $display("test short frames done");
        repeat (2) frame_b(0, 12'h000);
        check({14'h0, pwr_b}, {14'h0, PWR_NAP});
        wake_b();
        check({14'h0, pwr_b}, {14'h0, PWR_ACTIVE});
        repeat (4) frame_b(0, 12'h000);
        check({14'h0, pwr_b}, {14'h0, PWR_SLEEP});
        wake_b();
        check({14'h0, pwr_b}, {14'h0, PWR_ACTIVE});
        $display("test power states done");
        stop_test();
    end

    // watchdog: runs take about 1270 cycles, allow nearly eight times that
    initial begin
        #100000;
        failures++;
        stop_test();
    end
endmodule
